// File: verilog/def_pkg.sv
// Constants, register layout and types of the directional earth fault stage pair
// What this block does
// - Switched submode: select input picks reactive/active
// - Active mode uses resistive current component only
// - Reactive mode uses capacitive current component only
// - Component modes trip in base-angle half plane
// - Wedge mode: sector, half width up to 88 degrees
// - Amplitude mode ignores angle and voltage
// - Source: residual one, two or summed phases
// - Summed residual is sum of phase currents
// - Restart within intermittent time keeps delay count
// - Two stages, fixed or inverse delay each
// - Four setting groups, one active
// - Residual saturates at 10x, phase at 50x
// - Start threshold limits depend on stage, source
// - Voltage threshold 1 to 100 percent
// - Base angle -180..179, operate angle 88 max
// - Fixed delay up to 300 s, 20 ms steps
// - Multiplier 0.025..20, 0.5 minimum some families
// - Start on all criteria, trip after delay
package def_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 20;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] REG_CTRL = 8'h80;
  localparam logic [7:0] REG_STATUS = 8'h81;
  localparam logic [3:0] F_CFG = 4'h0;
  localparam logic [3:0] F_THR = 4'h1;
  localparam logic [3:0] F_VTHR = 4'h2;
  localparam logic [3:0] F_BASE = 4'h3;
  localparam logic [3:0] F_OPANG = 4'h4;
  localparam logic [3:0] F_OPTIME = 4'h5;
  localparam logic [3:0] F_K = 4'h6;
  localparam logic [3:0] F_ITIME = 4'h7;
  localparam int CFG_SRC_LSB = 3;
  localparam int CFG_DLY_BIT = 5;
  localparam int CFG_FAM_LSB = 6;
  localparam int CFG_EVT_BIT = 8;
  localparam int RES_SAT = 10000;
  localparam int PH_SAT = 50000;
  localparam int THR_MIN_ONE = 1;
  localparam int THR_MIN_TWO = 10;
  localparam int THR_MAX_SUM = 20000;
  localparam int THR_MAX_IN = 8000;
  localparam int VTHR_MIN = 1;
  localparam int VTHR_MAX = 100;
  localparam int OPANG_MAX = 88;
  localparam int BASE_MIN = -180;
  localparam int BASE_MAX = 179;
  localparam int OPTIME_MIN = 5;
  localparam int OPTIME_MAX = 15000;
  localparam int K_MIN = 25;
  localparam int K_MIN_STEEP = 500;
  localparam int K_MAX = 20000;
  localparam int CURVE_GAIN = 4;
  localparam logic [8:0] RST_CFG = 9'h001;
  localparam logic [14:0] RST_THR = 15'h0064;
  localparam logic [6:0] RST_VTHR = 7'h0a;
  localparam logic [6:0] RST_OPANG = 7'h58;
  localparam logic [13:0] RST_OPTIME = 14'h0005;
  localparam logic [14:0] RST_K = 15'h03e8;
  typedef enum logic [2:0] {
    MODE_UNDIR = 3'b000,
    MODE_ACTIVE = 3'b001,
    MODE_REACTIVE = 3'b010,
    MODE_SWITCHED = 3'b011,
    MODE_WEDGE = 3'b100
  } def_mode_type;
  typedef enum logic [1:0] {
    SRC_ONE = 2'b00,
    SRC_TWO = 2'b01,
    SRC_SUM = 2'b10
  } def_src_type;
  typedef enum logic [1:0] {
    FAM_IEC = 2'b00,
    FAM_IEEE = 2'b01,
    FAM_RI = 2'b10
  } def_fam_type;
  typedef struct packed {
    logic [8:0] cfg;
    logic [14:0] thr;
    logic [6:0] vthr;
    logic signed [8:0] base;
    logic [6:0] opang;
    logic [13:0] optime;
    logic [14:0] k;
    logic [13:0] itime;
  } def_set_type;
  typedef struct packed {
    logic start;
    logic trip;
    logic start_ev;
    logic trip_ev;
    logic [13:0] cnt;
    logic [47:0] acc;
    logic [13:0] icnt;
    logic ilive;
  } def_stage_type;
endpackage : def_pkg

// File: verilog/def_stage_pair.sv
// Two directional earth fault stages with settings registers
`timescale 1ns/1ps
module def_stage_pair #(
  parameter int TICK_CYCLES = def_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic submode_select_input,
  input wire logic [1:0] block_in,
  input wire logic signed [15:0] residual_input_one_re,
  input wire logic signed [15:0] residual_input_one_im,
  input wire logic signed [15:0] residual_input_two_re,
  input wire logic signed [15:0] residual_input_two_im,
  input wire logic signed [16:0] phase_l1_re,
  input wire logic signed [16:0] phase_l1_im,
  input wire logic signed [16:0] phase_l2_re,
  input wire logic signed [16:0] phase_l2_im,
  input wire logic signed [16:0] phase_l3_re,
  input wire logic signed [16:0] phase_l3_im,
  input wire logic [7:0] neutral_voltage_mag,
  input wire logic signed [8:0] neutral_voltage_ang,
  output logic [1:0] start,
  output logic [1:0] trip,
  output logic [1:0] start_event,
  output logic [1:0] trip_event
);
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  typedef struct packed {
    def_pkg::def_set_type [1:0][3:0] set;
    def_pkg::def_stage_type [1:0] stg;
    logic [1:0] grp;
    logic [31:0] rdata;
    logic [PRE_W-1:0] pre;
    logic tick;
  } def_state_type;
  def_state_type st;
  def_state_type next_st;
  logic [1:0] volt_c;
  longint act_c [2];
  longint react_c [2];
  longint mag2_c [2];
  int thr_c [2];

  function automatic int clampi(input int v, input int lo, input int hi);
    int r;
    r = v;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r;
  endfunction : clampi
  // Rational sine approximation in Q14; avoids a table and stays within 0.2 percent
  function automatic int sin_q14(input int deg);
    int d;
    int p;
    int r;
    d = deg % 360;
    if (d < 0) d = d + 360;
    if (d < 180)
    begin
      p = d * (180 - d);
      r = (4 * p * 16384) / (40500 - p);
    end
    else
    begin
      p = (d - 180) * (360 - d);
      r = -((4 * p * 16384) / (40500 - p));
    end
    return r;
  endfunction : sin_q14
  always_comb
  begin
    int s;
    int sre;
    int sim;
    int ire;
    int iim;
    int ref_a;
    int cosr;
    int sinr;
    int cq;
    int kmin;
    int k_i;
    int thr_i;
    int wv;
    longint thr2;
    longint q2;
    longint comp;
    longint act2;
    logic hit;
    logic blk;
    def_pkg::def_set_type g;
    def_pkg::def_mode_type mode;
    def_pkg::def_src_type src;
    def_pkg::def_fam_type fam;
    logic [31:0] rval;
    s = 0;
    sre = 0;
    sim = 0;
    wv = 0;
    ire = 0;
    iim = 0;
    ref_a = 0;
    cosr = 0;
    sinr = 0;
    cq = 0;
    kmin = 0;
    k_i = 0;
    thr_i = 0;
    thr2 = 0;
    q2 = 0;
    comp = 0;
    act2 = 0;
    hit = 1'b0;
    blk = 1'b0;
    g = '0;
    mode = def_pkg::MODE_UNDIR;
    src = def_pkg::SRC_ONE;
    fam = def_pkg::FAM_IEC;
    rval = 32'h0;
    volt_c = 2'b00;
    act_c = '{0, 0};
    react_c = '{0, 0};
    mag2_c = '{0, 0};
    thr_c = '{0, 0};
    next_st = st;
    // Time base for all delays
    next_st.tick = 1'b0;
    if (int'(st.pre) >= TICK_CYCLES - 1)
    begin
      next_st.pre = '0;
      next_st.tick = 1'b1;
    end
    else
      next_st.pre = PRE_W'(int'(st.pre) + 1);
    // Summed residual from phase currents, each clipped at its saturation level
    sre = clampi(int'(phase_l1_re), -def_pkg::PH_SAT, def_pkg::PH_SAT)
        + clampi(int'(phase_l2_re), -def_pkg::PH_SAT, def_pkg::PH_SAT)
        + clampi(int'(phase_l3_re), -def_pkg::PH_SAT, def_pkg::PH_SAT);
    sim = clampi(int'(phase_l1_im), -def_pkg::PH_SAT, def_pkg::PH_SAT)
        + clampi(int'(phase_l2_im), -def_pkg::PH_SAT, def_pkg::PH_SAT)
        + clampi(int'(phase_l3_im), -def_pkg::PH_SAT, def_pkg::PH_SAT);

    for (s = 0; s < 2; s++)
    begin
      g = st.set[s][st.grp];
      mode = def_pkg::def_mode_type'(g.cfg[2:0]);
      src = def_pkg::def_src_type'(g.cfg[def_pkg::CFG_SRC_LSB +: 2]);
      fam = def_pkg::def_fam_type'(g.cfg[def_pkg::CFG_FAM_LSB +: 2]);
      unique case (src)
        def_pkg::SRC_TWO:
        begin
          ire = clampi(int'(residual_input_two_re), -def_pkg::RES_SAT, def_pkg::RES_SAT);
          iim = clampi(int'(residual_input_two_im), -def_pkg::RES_SAT, def_pkg::RES_SAT);
        end
        def_pkg::SRC_SUM:
        begin
          ire = sre;
          iim = sim;
        end
        default:
        begin
          ire = clampi(int'(residual_input_one_re), -def_pkg::RES_SAT, def_pkg::RES_SAT);
          iim = clampi(int'(residual_input_one_im), -def_pkg::RES_SAT, def_pkg::RES_SAT);
        end
      endcase
      thr_i = clampi(int'(g.thr), (s == 0) ? def_pkg::THR_MIN_ONE : def_pkg::THR_MIN_TWO,
                     (src == def_pkg::SRC_SUM) ? def_pkg::THR_MAX_SUM : def_pkg::THR_MAX_IN);
      thr2 = longint'(thr_i) * longint'(thr_i);
      // Rotate the current into the frame of the voltage turned by the base angle
      ref_a = int'(neutral_voltage_ang) + int'(g.base);
      cosr = sin_q14(ref_a + 90);
      sinr = sin_q14(ref_a);
      act_c[s] = (longint'(ire) * cosr + longint'(iim) * sinr) >>> 14;
      react_c[s] = (longint'(iim) * cosr - longint'(ire) * sinr) >>> 14;
      mag2_c[s] = act_c[s] * act_c[s] + react_c[s] * react_c[s];
      thr_c[s] = thr_i;
      volt_c[s] = int'(neutral_voltage_mag) >= int'(g.vthr);
      cq = sin_q14(int'(g.opang) + 90) >>> 6;
      act2 = act_c[s] * act_c[s];
      comp = 0;
      hit = 1'b0;
      unique case (mode)
        def_pkg::MODE_ACTIVE: comp = act_c[s];
        def_pkg::MODE_REACTIVE: comp = react_c[s];
        def_pkg::MODE_SWITCHED: comp = submode_select_input ? react_c[s] : act_c[s];
        default: comp = 0;
      endcase
      if (mode == def_pkg::MODE_UNDIR)
      begin
        hit = mag2_c[s] >= thr2;
        q2 = mag2_c[s];
      end
      else if (mode == def_pkg::MODE_WEDGE)
      begin
        // Inside the sector when cos of the offset from base is at least cos of half width
        hit = volt_c[s] && act_c[s] > 0 && mag2_c[s] >= thr2
              && (act2 <<< 16) >= mag2_c[s] * longint'(cq) * longint'(cq);
        q2 = mag2_c[s];
      end
      else
      begin
        hit = volt_c[s] && comp >= longint'(thr_i);
        q2 = comp * comp;
      end
      kmin = (fam == def_pkg::FAM_IEEE || fam == def_pkg::FAM_RI)
             ? def_pkg::K_MIN_STEEP : def_pkg::K_MIN;
      k_i = clampi(int'(g.k), kmin, def_pkg::K_MAX);
      blk = block_in[s];
      next_st.stg[s].start_ev = 1'b0;
      next_st.stg[s].trip_ev = 1'b0;
      if (hit && !blk)
      begin
        next_st.stg[s].start = 1'b1;
        next_st.stg[s].ilive = 1'b0;
        next_st.stg[s].icnt = '0;
        if (st.tick)
        begin
          if (!g.cfg[def_pkg::CFG_DLY_BIT])
          begin
            if (st.stg[s].cnt < g.optime)
              next_st.stg[s].cnt = st.stg[s].cnt + 14'h0001;
          end
          else if (st.stg[s].acc < 48'(longint'(def_pkg::CURVE_GAIN) * k_i * thr2))
            // Integrates (M^2-1); stops once reached so the sum cannot wrap
            next_st.stg[s].acc = st.stg[s].acc + 48'(q2 - thr2);
        end
        if (!g.cfg[def_pkg::CFG_DLY_BIT])
          next_st.stg[s].trip = next_st.stg[s].cnt >= g.optime;
        else
          next_st.stg[s].trip = next_st.stg[s].acc
                                >= 48'(longint'(def_pkg::CURVE_GAIN) * k_i * thr2);
      end
      else
      begin
        next_st.stg[s].start = 1'b0;
        next_st.stg[s].trip = 1'b0;
        if (st.stg[s].start)
        begin
          if (g.itime == 14'h0000)
          begin
            next_st.stg[s].cnt = '0;
            next_st.stg[s].acc = '0;
          end
          else
          begin
            next_st.stg[s].ilive = 1'b1;
            next_st.stg[s].icnt = g.itime;
          end
        end
        else if (st.stg[s].ilive && st.tick)
        begin
          if (st.stg[s].icnt <= 14'h0001)
          begin
            next_st.stg[s].ilive = 1'b0;
            next_st.stg[s].cnt = '0;
            next_st.stg[s].acc = '0;
          end
          else
            next_st.stg[s].icnt = st.stg[s].icnt - 14'h0001;
        end
      end
      if (g.cfg[def_pkg::CFG_EVT_BIT])
      begin
        next_st.stg[s].start_ev = next_st.stg[s].start && !st.stg[s].start;
        next_st.stg[s].trip_ev = next_st.stg[s].trip && !st.stg[s].trip;
      end
    end

    // Register writes; out-of-range voltage threshold, base, operate angle and delay values are pulled to the nearest legal setting
    wv = int'(wdata[15:0]);
    if (wr && !addr[7])
    begin
      unique case (addr[3:0])
        def_pkg::F_CFG: next_st.set[addr[6]][addr[5:4]].cfg = wdata[8:0];
        def_pkg::F_THR: next_st.set[addr[6]][addr[5:4]].thr = wdata[14:0];
        def_pkg::F_VTHR:
          next_st.set[addr[6]][addr[5:4]].vthr =
            7'(clampi(wv, def_pkg::VTHR_MIN, def_pkg::VTHR_MAX));
        def_pkg::F_BASE:
          next_st.set[addr[6]][addr[5:4]].base = 9'(clampi(int'(signed'(wdata[8:0])),
            def_pkg::BASE_MIN, def_pkg::BASE_MAX));
        def_pkg::F_OPANG:
          next_st.set[addr[6]][addr[5:4]].opang =
            7'(clampi(wv, 0, def_pkg::OPANG_MAX));
        def_pkg::F_OPTIME:
          next_st.set[addr[6]][addr[5:4]].optime =
            14'(clampi(wv, def_pkg::OPTIME_MIN, def_pkg::OPTIME_MAX));
        def_pkg::F_K: next_st.set[addr[6]][addr[5:4]].k = wdata[14:0];
        def_pkg::F_ITIME: next_st.set[addr[6]][addr[5:4]].itime = wdata[13:0];
        default: next_st.grp = st.grp;
      endcase
    end
    else if (wr && addr == def_pkg::REG_CTRL)
      next_st.grp = wdata[1:0];

    if (rd && !addr[7])
    begin
      g = st.set[addr[6]][addr[5:4]];
      unique case (addr[3:0])
        def_pkg::F_CFG: rval = {23'h0, g.cfg};
        def_pkg::F_THR: rval = {17'h0, g.thr};
        def_pkg::F_VTHR: rval = {25'h0, g.vthr};
        def_pkg::F_BASE: rval = {{23{g.base[8]}}, g.base};
        def_pkg::F_OPANG: rval = {25'h0, g.opang};
        def_pkg::F_OPTIME: rval = {18'h0, g.optime};
        def_pkg::F_K: rval = {17'h0, g.k};
        def_pkg::F_ITIME: rval = {18'h0, g.itime};
        default: rval = 32'h0;
      endcase
    end
    else if (rd && addr == def_pkg::REG_CTRL)
      rval = {30'h0, st.grp};
    else if (rd && addr == def_pkg::REG_STATUS)
      rval = {26'h0, st.grp, st.stg[1].trip, st.stg[0].trip, st.stg[1].start, st.stg[0].start};
    next_st.rdata = rval;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      for (int s = 0; s < 2; s++)
      begin
        for (int gi = 0; gi < 4; gi++)
        begin
          st.set[s][gi].cfg <= def_pkg::RST_CFG;
          st.set[s][gi].thr <= def_pkg::RST_THR;
          st.set[s][gi].vthr <= def_pkg::RST_VTHR;
          st.set[s][gi].opang <= def_pkg::RST_OPANG;
          st.set[s][gi].optime <= def_pkg::RST_OPTIME;
          st.set[s][gi].k <= def_pkg::RST_K;
        end
      end
    end
    else
      st <= next_st;
  end

  assign rdata = st.rdata;
  assign start = {st.stg[1].start, st.stg[0].start};
  assign trip = {st.stg[1].trip, st.stg[0].trip};
  assign start_event = {st.stg[1].start_ev, st.stg[0].start_ev};
  assign trip_event = {st.stg[1].trip_ev, st.stg[0].trip_ev};

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  block_quiet_a: assert property (block_in[0] |=> !start[0] && !trip[0])
    else $error("stage one active while blocked");
  trip_start_a: assert property (trip[1] |-> start[1])
    else $error("trip without start");
  event_edge_a: assert property (start_event[0] |-> start[0] && !$past(start[0]))
    else $error("start event without rising start");
  active_start_a: assert property (st.set[0][st.grp].cfg[2:0] == def_pkg::MODE_ACTIVE
    && !block_in[0] && volt_c[0] && act_c[0] >= thr_c[0] |=> start[0])
    else $error("active component over threshold did not start");
  switch_sel_a: assert property (st.set[0][st.grp].cfg[2:0] == def_pkg::MODE_SWITCHED
    && submode_select_input && react_c[0] < thr_c[0] |=> !start[0])
    else $error("switched submode ignored reactive selection");
  undir_start_a: assert property (st.set[0][st.grp].cfg[2:0] == def_pkg::MODE_UNDIR
    && !block_in[0] && mag2_c[0] >= longint'(thr_c[0]) * thr_c[0] |=> start[0])
    else $error("amplitude mode did not start");
  thr_limit_a: assert property (thr_c[1] >= def_pkg::THR_MIN_TWO
    && thr_c[1] <= def_pkg::THR_MAX_SUM)
    else $error("second stage threshold out of range");
  keep_count_a: assert property ($fell(start[0]) && $past(st.set[0][st.grp].itime) != 14'h0
    && $past(st.grp) == st.grp |-> st.stg[0].cnt == $past(st.stg[0].cnt, 1))
    else $error("delay count lost inside intermittent window");
  clear_count_a: assert property ($fell(start[0]) && $past(st.set[0][st.grp].itime) == 14'h0
    && $past(st.grp) == st.grp |-> st.stg[0].cnt == 14'h0 && st.stg[0].acc == 48'h0)
    else $error("delay count kept with no intermittent time");
endmodule : def_stage_pair

// File: tb/def_front_model.sv
// Measurement front end model: routes one commanded phasor to the chosen source
`timescale 1ns/1ps
module def_front_model (
  input wire logic clk,
  input wire logic [1:0] route,
  input wire logic signed [15:0] cre,
  input wire logic signed [15:0] cim,
  output logic signed [15:0] r1_re,
  output logic signed [15:0] r1_im,
  output logic signed [15:0] r2_re,
  output logic signed [15:0] r2_im,
  output logic signed [16:0] ph_re,
  output logic signed [16:0] ph_im
);
  // Unselected sources carry a large current of flipping sign, never a quiet zero
  logic signed [15:0] decoy = 16'sh1388;
  always_ff @(posedge clk)
  begin
    decoy <= -decoy;
    r1_re <= (route == 2'h0) ? cre : decoy;
    r1_im <= (route == 2'h0) ? cim : decoy;
    r2_re <= (route == 2'h1) ? cre : decoy;
    r2_im <= (route == 2'h1) ? cim : decoy;
    // Even split: only the three-phase sum reaches the commanded value
    ph_re <= (route == 2'h2) ? 17'(cre / 3) : 17'(decoy);
    ph_im <= (route == 2'h2) ? 17'(cim / 3) : 17'(decoy);
  end
endmodule : def_front_model

// File: tb/tb_def_stage_pair.sv
// Self-checking bench of the directional earth fault stage pair
`timescale 1ns/1ps
module tb_def_stage_pair;
  localparam int MC[6] = '{0, 1, 2, 3, 3, 4};
  localparam int MD[6] = '{0, 0, 0, 0, 1, 0};
  localparam int EM[6] = '{0, 1, 2, 1, 2, 3};
  localparam int PR[6] = '{2000, 0, -2000, 940, 500, 940};
  localparam int PI[6] = '{0, 2000, 0, 342, 866, -342};
  localparam int PV[6] = '{50, 50, 50, 50, 50, 5};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic di = 1'b0;
  logic [1:0] blk = 2'h0;
  logic [1:0] route = 2'h0;
  logic signed [15:0] cre = 16'sh0;
  logic signed [15:0] cim = 16'sh0;
  logic [7:0] vmag = 8'h0;
  logic signed [8:0] vang = 9'sh0;
  logic signed [15:0] r1_re, r1_im, r2_re, r2_im;
  logic signed [16:0] ph_re, ph_im;
  logic [1:0] start, trip, start_event, trip_event;
  logic [31:0] seed = 32'h3c;
  logic [31:0] d;
  int bad_count = 0;
  int n_tests = 0;
  int ev_n = 0;
  int n, re, im, v, m, e;
  always #10 clk = ~clk;
  always @(posedge clk) if (start_event[0] === 1'b1) ev_n++;
  def_front_model def_front_model_i (.clk(clk), .route(route), .cre(cre), .cim(cim),
    .r1_re(r1_re), .r1_im(r1_im), .r2_re(r2_re), .r2_im(r2_im), .ph_re(ph_re), .ph_im(ph_im));
  def_stage_pair #(.TICK_CYCLES(10)) def_stage_pair_i (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .submode_select_input(di), .block_in(blk),
    .residual_input_one_re(r1_re), .residual_input_one_im(r1_im),
    .residual_input_two_re(r2_re), .residual_input_two_im(r2_im),
    .phase_l1_re(ph_re), .phase_l1_im(ph_im), .phase_l2_re(ph_re), .phase_l2_im(ph_im),
    .phase_l3_re(ph_re), .phase_l3_im(ph_im), .neutral_voltage_mag(vmag),
    .neutral_voltage_ang(vang), .start(start), .trip(trip), .start_event(start_event),
    .trip_event(trip_event));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  function automatic logic [7:0] sa(input int s, input int g, input int f);
    return {1'b0, 1'(s), 2'(g), 4'(f)};
  endfunction : sa
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Voltage angle and base are zero here, so re is resistive and +im capacitive
  function automatic logic exp_start(input int md, input int r, input int i, input int vv,
    input int thr);
    logic vok;
    vok = vv > 10;
    case (md)
      0: return r * r + i * i > thr * thr;
      1: return vok && r > thr;
      2: return vok && i > thr;
      default: return vok && r * r + i * i > thr * thr && (i < 0 ? -i : i) * 1000 <= r * 577;
    endcase
  endfunction : exp_start
  task automatic wreg(input logic [7:0] a, input logic [31:0] val);
    @(posedge clk);
    addr <= a;
    wdata <= val;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] val);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 val = rdata;
  endtask : rreg
  task automatic drive(input int r, input int pr, input int pi, input int pv);
    @(posedge clk);
    route <= 2'(r);
    cre <= 16'(pr);
    cim <= 16'(pi);
    vmag <= 8'(pv);
    repeat (4) @(posedge clk);
    #1;
  endtask : drive
  task automatic wait_trip(output int cnt);
    cnt = 0;
    while (trip[0] !== 1'b1)
    begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 300)
      begin
        chk("trip_wait", 0, 1);
        end_of_test();
      end
    end
  endtask : wait_trip
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rreg(sa(0, 0, 0), d);
    chk("cfg_rst", d, 32'h1);
    rreg(sa(0, 0, 1), d);
    chk("thr_rst", d, 32'h64);
    rreg(8'h82, d);
    chk("unmapped", d, 32'h0);
    wreg(sa(0, 0, 2), 32'hc8);
    rreg(sa(0, 0, 2), d);
    chk("vthr_clamp", d, 32'h64);
    wreg(sa(0, 0, 2), 32'ha);
    wreg(sa(0, 0, 4), 32'h64);
    rreg(sa(0, 0, 4), d);
    chk("opang_clamp", d, 32'h58);
    wreg(sa(0, 0, 4), 32'h1e);
    wreg(sa(0, 3, 3), 32'hc8);
    rreg(sa(0, 3, 3), d);
    chk("base_clamp", d, 32'hb3);
    for (int k = 0; k < 6; k++)
      for (int p = 0; p < 6; p++)
      begin
        wreg(sa(0, 0, 0), 32'(MC[k]));
        di <= 1'(MD[k]);
        drive(0, PR[p], PI[p], PV[p]);
        chk("start_mode", start[0], exp_start(EM[k], PR[p], PI[p], PV[p], 100));
        drive(0, 0, 0, 50);
      end
    for (int k = 0; k < 40; k++)
    begin
      seed = xs(seed);
      re = int'(seed[8:0]) - 256;
      im = int'(seed[17:9]) - 256;
      v = int'(seed[24:18]);
      m = int'(seed[26:25]);
      e = (m == 3) ? (seed[27] ? 2 : 1) : m;
      n = re * re + im * im;
      if ((n > 8100 && n < 12100) || (re > 90 && re < 110) || (im > 90 && im < 110))
        continue;
      if (v > 7 && v < 13)
        continue;
      wreg(sa(0, 0, 0), 32'(m));
      di <= seed[27];
      drive(0, re, im, v);
      chk("start_rand", start[0], exp_start(e, re, im, v, 100));
      drive(0, 0, 0, 50);
    end
    wreg(sa(0, 0, 1), 32'hfa);
    for (int s = 0; s < 3; s++)
    begin
      wreg(sa(0, 0, 0), 32'(s << 3));
      drive(s, 300, 0, 50);
      chk("src_on", start[0], 1);
      drive(s, 0, 0, 50);
      chk("src_off", start[0], 0);
    end
    wreg(sa(0, 0, 0), 32'h0);
    wreg(sa(1, 0, 0), 32'h0);
    wreg(sa(0, 0, 1), 32'h1);
    wreg(sa(1, 0, 1), 32'h1);
    drive(0, 5, 0, 50);
    chk("thr_min", start, 2'b01);
    wreg(sa(0, 0, 1), 32'h3a98);
    drive(0, 9000, 0, 50);
    chk("thr_max", start[0], 1);
    wreg(sa(0, 0, 1), 32'h64);
    drive(0, 2000, 0, 50);
    rreg(8'h81, d);
    chk("status", {d[5:4], d[0]}, 3'b001);
    wreg(sa(0, 1, 1), 32'hbb8);
    wreg(8'h80, 32'h1);
    drive(0, 2000, 0, 50);
    chk("group", start[0], 0);
    rreg(8'h81, d);
    chk("status_grp", d[5:4], 2'h1);
    wreg(8'h80, 32'h0);
    drive(0, 0, 0, 50);
    chk("ev_off", ev_n, 0);
    wreg(sa(0, 0, 0), 32'h100);
    blk <= 2'b01;
    drive(0, 2000, 0, 50);
    chk("block", start, 2'b10);
    ev_n = 0;
    blk <= 2'b00;
    drive(0, 2000, 0, 50);
    wait_trip(n);
    chk("trip_time", n >= 34 && n <= 56, 1);
    chk("ev_on", ev_n, 1);
    chk("trip_ev", trip_event, 2'b01);
    for (int k = 0; k < 2; k++)
    begin
      wreg(sa(0, 0, 7), k ? 32'h0 : 32'h14);
      drive(0, 0, 0, 50);
      repeat (300) @(posedge clk);
      drive(0, 2000, 0, 50);
      repeat (25) @(posedge clk);
      drive(0, 0, 0, 50);
      drive(0, 2000, 0, 50);
      wait_trip(n);
      chk("intermittent", n < 33, k ? 0 : 1);
    end
    for (int k = 0; k < 2; k++)
    begin
      wreg(sa(0, 0, 0), k ? 32'h20 : 32'h60);
      wreg(sa(0, 0, 6), k ? 32'h4e20 : 32'h19);
      drive(0, 0, 0, 50);
      drive(0, k ? 30000 : 2000, 0, 50);
      wait_trip(n);
      chk("inverse", n >= (k ? 78 : 48) && n <= (k ? 87 : 57), 1);
      chk("trip_ev_off", trip_event[0], 0);
    end
    wreg(sa(0, 0, 0), 32'h1);
    vang <= 9'sd90;
    drive(0, 0, 2000, 50);
    chk("angle", start[0], 1);
    wreg(sa(0, 0, 3), 32'h1a6);
    drive(0, 0, 2000, 50);
    chk("base", start[0], 0);
    end_of_test();
  end
endmodule : tb_def_stage_pair
